//--- dv/rcu_dram_model.sv
// Clocked DRAM controller model on the refresh block's bus pins
`timescale 1ns/1ps
module rcu_dram_model (
  input  wire logic              clk,      // Processor clock
  input  wire logic              cyc,      // High through T1..T4
  input  wire rcu_pkg::rcu_bus_t bus,      // Address and byte pin
  output logic                   is_ref,   // Refresh cycle seen
  output logic [8:0]             row_addr, // Multiplexed DRAM address
  output logic                   ras_n,    // Row strobe
  output logic                   cas_n     // Column strobe
);
  logic [2:0] t_q;
  logic       col_q;

  assign is_ref = bus.bhe_n & bus.addr[0];
  // A0 is constant in refresh, so it never reaches the row pins
  assign row_addr = col_q ? bus.addr[18:10] : bus.addr[9:1];

  always @(posedge clk) begin
    t_q   <= cyc ? t_q + 3'h1 : 3'h0;
    col_q <= cyc && (t_q == 3'h1 || t_q == 3'h2);
  end

  always @(negedge clk) begin
    ras_n <= !(t_q == 3'h2 || t_q == 3'h3);
    cas_n <= !(t_q == 3'h3 && !is_ref);
  end
endmodule // rcu_dram_model

//--- dv/rcu_refresh_tb_top.sv
// Self-checking bench for the refresh address and cycle block
`timescale 1ns/1ps
module rcu_refresh_tb_top;
  localparam logic [8:0] ROW0 = 9'h000;
  localparam logic [6:0] BASE = 7'h55;
  logic              clk, sys_rst, refresh_cycle, refresh_done, cpu_bhe_n;
  logic              req, is_ref, ras_n, cas_n;
  logic [1:0]        reg_rd_idx;
  logic [19:0]       cpu_addr;
  logic [15:0]       rdata;
  logic [8:0]        row_addr, r, first;
  logic [511:0]      seen;
  rcu_pkg::rcu_wr_t  reg_wr;
  rcu_pkg::rcu_bus_t bus_q, bus8_q;
  int                err_count, n_compared, i, n;
  logic [15:0]       tbl [6][3] = '{'{16'h0, 16'hFFFF, 16'h007F},
    '{16'h1, 16'hFFFF, 16'h01FF}, '{16'h3, 16'hFFFF, 16'h0000},
    '{16'h2, 16'h01FF, 16'h0000}, '{16'h1, 16'h0000, 16'h0000},
    '{16'h0, 16'h0055, 16'h0055}};

  rcu_refresh #(.BUS16(1'b1), .ROW_START(ROW0)) i_rcu_refresh (.clk(clk),
    .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd_idx(reg_rd_idx),
    .cpu_addr(cpu_addr), .cpu_bhe_n(cpu_bhe_n), .refresh_cycle(refresh_cycle),
    .refresh_done(refresh_done), .bus_q(bus_q), .reg_rdata_q(rdata),
    .refresh_req_q(req));
  rcu_refresh #(.BUS16(1'b0)) i_rcu_refresh_b8 (.clk(clk), .sys_rst(sys_rst),
    .reg_wr(reg_wr), .reg_rd_idx(reg_rd_idx), .cpu_addr(cpu_addr),
    .cpu_bhe_n(cpu_bhe_n), .refresh_cycle(refresh_cycle),
    .refresh_done(refresh_done), .bus_q(bus8_q), .reg_rdata_q(),
    .refresh_req_q());
  rcu_dram_model i_rcu_dram_model (.clk(clk), .cyc(refresh_cycle),
    .bus(bus_q), .is_ref(is_ref), .row_addr(row_addr), .ras_n(ras_n),
    .cas_n(cas_n));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Bus tasks, each entered at an edge or 1 ns after it, and left in an edge time step
  // ----------------------------------------------------------------
  task automatic wr(input logic [1:0] idx, input logic [15:0] d);
    reg_wr <= '{1'b1, idx, d};
    @(posedge clk);
    reg_wr.wr <= 1'b0;
    // Gap edge: a following write never re-drives the strobe at once
    @(posedge clk);
  endtask

  task automatic rd(input logic [1:0] idx, input logic [15:0] exp);
    reg_rd_idx <= idx;
    @(posedge clk);
    #1;
    chk(24'(rdata), 24'(exp));
    @(posedge clk);
  endtask

  task automatic do_ref(output logic [8:0] row);
    refresh_cycle <= 1'b1;
    @(posedge clk);
    #1;
    chk(24'(bus_q.addr[19:10]), {14'h0, BASE, 3'h0});
    chk({bus_q.addr[0], bus_q.bhe_n, bus8_q.bhe_n, is_ref}, 24'hD);
    row = row_addr;
    @(posedge clk);
    refresh_cycle <= 1'b0;
    refresh_done  <= 1'b1;
    @(negedge clk);
    #1;
    chk(24'({row_addr, ras_n, cas_n}), 24'({BASE[5:0], 3'h0, 2'b01}));
    @(posedge clk);
    refresh_done <= 1'b0;
  endtask

  initial begin
    sys_rst = 1'b1;
    refresh_cycle = 1'b0;
    refresh_done = 1'b0;
    cpu_bhe_n = 1'b1;
    cpu_addr = 20'h0;
    reg_rd_idx = 2'h0;
    reg_wr = '0;
    err_count = 0;
    n_compared = 0;
    seen = '0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 6; i++) begin
      wr(tbl[i][0][1:0], tbl[i][1]);
      rd(tbl[i][0][1:0], tbl[i][2]);
    end
    sys_rst <= 1'b1;
    @(posedge clk);
    #1;
    chk(24'({bus_q, req}), 24'h0); // Reset clears pins and request
    sys_rst <= 1'b0;
    for (i = 0; i < 3; i++) rd(2'(i), 16'h0);
    wr(2'h0, {9'h0, BASE});
    cpu_addr  <= 20'hABCDE;
    cpu_bhe_n <= 1'b0;
    @(posedge clk);
    #1;
    chk({bus_q.addr, bus_q.bhe_n}, {3'h0, 20'hABCDE, 1'b0});
    @(posedge clk);
    for (i = 0; i < 512; i++) begin
      do_ref(r);
      if (i == 0) first = r;
      chk(24'(seen[r]), 24'h0);
      seen[r] = 1'b1;
    end
    chk(24'(first), 24'(ROW0));
    do_ref(r);
    chk(24'(r), 24'(first));
    wr(2'h1, 16'h01FF);
    wr(2'h2, 16'h8000);
    n = 0;
    while (req !== 1'b1 && n < 600) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(24'(n), 24'd511);
    do_ref(r);
    @(posedge clk);
    #1;
    chk(24'(req), 24'h0);
    n = 4;
    while (req !== 1'b1 && n < 600) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(24'(n), 24'd511);
    wr(2'h2, 16'h0000);
    rd(2'h2, 16'h0000);
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    finish_test();
  end
endmodule // rcu_refresh_tb_top

//--- verilog/rcu_pkg.sv
// Package of constants and types for the refresh address and cycle block
//
// Notes on behaviour
// - Refresh cycles drive address bits 19:13 from the refresh base value.
// - Refresh cycles drive address bits 12:10 as zero, always.
// - Address bits 9:1 come from a shift counter visiting all 512 values.
// - Address bit 0 stays one through every refresh, both bus widths.
// - Refresh is a memory read; 16-bit version drives byte enable and bit 0 high.
// - 8-bit version drives active-low refresh indicator low, bit 0 high.
// - Seven-bit base places the refresh region on any 8 Kbyte boundary.
// - Row counter wrap never carries into the refresh base value.
// - Three consecutive registers: base, interval, control.
// - Interval counter decrements each clock; at one reloads and requests.
// - Row counter advances and request clears only on a completed refresh cycle.
// - Control enable starts or stops the unit; clearing it clears the counter.
package rcu_pkg;

  // ----------------------------------------------------------------
  // Register indices, consecutive
  // ----------------------------------------------------------------
  localparam logic [1:0] RCU_IDX_BASE     = 2'h0;
  localparam logic [1:0] RCU_IDX_INTERVAL = 2'h1;
  localparam logic [1:0] RCU_IDX_CONTROL  = 2'h2;

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int RCU_BASE_W   = 7;
  localparam int RCU_ROW_W    = 9;
  localparam int RCU_CNT_W    = 9;
  localparam int RCU_ADDR_W   = 20;
  localparam int RCU_EN_BIT   = 15;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [6:0] RCU_BASE_RST = 7'h00;
  localparam logic [8:0] RCU_CNT_RST  = 9'h000;
  localparam logic [8:0] RCU_ROW_RST  = 9'h000;

  // ----------------------------------------------------------------
  // Fixed refresh address pieces
  // ----------------------------------------------------------------
  localparam logic [2:0] RCU_ZERO_BITS = 3'h0;
  localparam logic       RCU_A0_REF    = 1'b1;

  // Address and byte-enable pins leaving toward the bus
  typedef struct packed {
    logic [19:0] addr;
    logic        bhe_n;
  } rcu_bus_t;

  // Register write request
  typedef struct packed {
    logic        wr;
    logic [1:0]  idx;
    logic [15:0] data;
  } rcu_wr_t;

endpackage

//--- verilog/rcu_refresh.sv
// Refresh address formation, interval counter and refresh cycle pins
`timescale 1ns/1ps
module rcu_refresh #(
  parameter bit             BUS16     = 1'b1,   // 1: 16-bit bus, 0: 8-bit
  parameter logic [8:0]     ROW_START = 9'h000  // Shift counter start value
) (
  input  wire logic              clk,           // 250 MHz clock
  input  wire logic              sys_rst,       // Sync reset, active high
  input  wire rcu_pkg::rcu_wr_t  reg_wr,        // Register write request
  input  wire logic [1:0]        reg_rd_idx,    // Register read index
  input  wire logic [19:0]       cpu_addr,      // Ordinary cycle address
  input  wire logic              cpu_bhe_n,     // Ordinary cycle byte enable
  input  wire logic              refresh_cycle, // Bus unit runs refresh
  input  wire logic              refresh_done,  // Refresh cycle completed
  output rcu_pkg::rcu_bus_t      bus_q,         // Address and bhe/refresh pin
  output logic [15:0]            reg_rdata_q,   // Register read data
  output logic                   refresh_req_q  // Refresh request to bus unit
);

  // ----------------------------------------------------------------
  // Shift counter step
  // ----------------------------------------------------------------
  // Taps 9,5 give 511 states; the zero-detect term splices in the
  // all-zero state so every row is visited once per pass.
  function automatic logic [8:0] lfsr_next(input logic [8:0] v);
    logic fb;
    fb = v[8] ^ v[4] ^ (v[7:0] == 8'h00);
    return {v[7:0], fb};
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [6:0]  base_q,     base_d;
  logic [8:0]  interval_q, interval_d;
  logic        en_q,       en_d;
  logic [8:0]  cnt_q,      cnt_d;
  logic [8:0]  row_q,      row_d;
  logic        req_d;
  logic [19:0] ref_addr;
  rcu_pkg::rcu_bus_t bus_d;
  logic [15:0] rdata_d;

  always_comb begin
    base_d     = base_q;
    interval_d = interval_q;
    en_d       = en_q;
    if (reg_wr.wr) begin
      case (reg_wr.idx)
        rcu_pkg::RCU_IDX_BASE:     base_d = reg_wr.data[6:0];
        rcu_pkg::RCU_IDX_INTERVAL: interval_d = reg_wr.data[8:0];
        rcu_pkg::RCU_IDX_CONTROL:  en_d = reg_wr.data[rcu_pkg::RCU_EN_BIT];
        default: begin
        end
      endcase
    end
  end

  // Interval counter and request
  always_comb begin
    if (!en_q) begin
      cnt_d = rcu_pkg::RCU_CNT_RST;
    end else if (cnt_q <= 9'h001) begin
      cnt_d = interval_q;
    end else begin
      cnt_d = cnt_q - 9'h001;
    end
    // Request is not queued: a new one while pending just stays set.
    // A set in the completing cycle wins over the clear.
    if (en_q && cnt_q == 9'h001) begin
      req_d = 1'b1;
    end else if (refresh_done) begin
      req_d = 1'b0;
    end else begin
      req_d = refresh_req_q;
    end
  end

  // Row counter, no carry into the base
  always_comb begin
    row_d = refresh_done ? lfsr_next(row_q) : row_q;
  end

  // Pins, registered: refresh values appear one cycle after the
  // bus unit flags the cycle.
  always_comb begin
    ref_addr = {base_q, rcu_pkg::RCU_ZERO_BITS, row_q,
                rcu_pkg::RCU_A0_REF};
    if (refresh_cycle) begin
      bus_d.addr  = ref_addr;
      bus_d.bhe_n = BUS16;
    end else begin
      bus_d.addr  = cpu_addr;
      bus_d.bhe_n = cpu_bhe_n;
    end
  end

  always_comb begin
    case (reg_rd_idx)
      rcu_pkg::RCU_IDX_BASE:     rdata_d = {9'h000, base_q};
      rcu_pkg::RCU_IDX_INTERVAL: rdata_d = {7'h00, interval_q};
      rcu_pkg::RCU_IDX_CONTROL:  rdata_d = {en_q, 6'h00, cnt_q};
      default:                   rdata_d = 16'h0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      base_q        <= rcu_pkg::RCU_BASE_RST;
      interval_q    <= rcu_pkg::RCU_CNT_RST;
      en_q          <= 1'b0;
      cnt_q         <= rcu_pkg::RCU_CNT_RST;
      row_q         <= ROW_START;
      refresh_req_q <= 1'b0;
      bus_q         <= '0;
      reg_rdata_q   <= 16'h0000;
    end else begin
      base_q        <= base_d;
      interval_q    <= interval_d;
      en_q          <= en_d;
      cnt_q         <= cnt_d;
      row_q         <= row_d;
      refresh_req_q <= req_d;
      bus_q         <= bus_d;
      reg_rdata_q   <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_ref;
    refresh_cycle;
  endsequence

  property p_upper;
    s_ref |=> bus_q.addr[19:13] == $past(base_q);
  endproperty
  a_upper: assert property (p_upper) else $error("bad upper bits");

  property p_zero;
    s_ref |=> bus_q.addr[12:10] == 3'h0;
  endproperty
  a_zero: assert property (p_zero) else $error("bits 12:10 not 0");

  property p_row;
    s_ref |=> bus_q.addr[9:1] == $past(row_q);
  endproperty
  a_row: assert property (p_row) else $error("row bits wrong");

  property p_a0;
    s_ref |=> bus_q.addr[0];
  endproperty
  a_a0: assert property (p_a0) else $error("bit 0 not one");

  property p_pin;
    s_ref |=> bus_q.bhe_n == BUS16;
  endproperty
  a_pin: assert property (p_pin) else $error("refresh pin wrong");

  property p_adv;
    refresh_done |=> row_q == lfsr_next($past(row_q)) && row_q != $past(row_q);
  endproperty
  a_adv: assert property (p_adv) else $error("row not advanced");

  property p_hold;
    !refresh_done |=> $stable(row_q);
  endproperty
  a_hold: assert property (p_hold) else $error("row moved");

  property p_nocarry;
    refresh_done && !(reg_wr.wr && reg_wr.idx == rcu_pkg::RCU_IDX_BASE)
      |=> $stable(base_q);
  endproperty
  a_nocarry: assert property (p_nocarry) else $error("base changed");

  property p_reload;
    en_q && cnt_q == 9'h001 |=> cnt_q == $past(interval_q) && refresh_req_q;
  endproperty
  a_reload: assert property (p_reload) else $error("no reload");

  property p_dis;
    !en_q |=> cnt_q == 9'h000;
  endproperty
  a_dis: assert property (p_dis) else $error("counter not cleared");

  property p_clr;
    refresh_done && !(en_q && cnt_q == 9'h001) |=> !refresh_req_q;
  endproperty
  a_clr: assert property (p_clr) else $error("request not cleared");

  property p_rd;
    reg_rd_idx == rcu_pkg::RCU_IDX_CONTROL
      |=> reg_rdata_q == {$past(en_q), 6'h00, $past(cnt_q)};
  endproperty
  a_rd: assert property (p_rd) else $error("control read wrong");

  property p_pass;
    !refresh_cycle |=> bus_q.addr == $past(cpu_addr)
      && bus_q.bhe_n == $past(cpu_bhe_n);
  endproperty
  a_pass: assert property (p_pass) else $error("pass-through wrong");

  property p_dec;
    en_q && cnt_q > 9'h001 |=> cnt_q == $past(cnt_q) - 9'h001;
  endproperty
  a_dec: assert property (p_dec) else $error("counter not stepped");

  property p_load0;
    en_q && cnt_q == 9'h000 |=> cnt_q == $past(interval_q);
  endproperty
  a_load0: assert property (p_load0) else $error("no load from zero");

  property p_sticky;
    refresh_req_q && !refresh_done |=> refresh_req_q;
  endproperty
  a_sticky: assert property (p_sticky) else $error("request lost");

  // Base takes the written value after its own write
  property p_base_wr;
    reg_wr.wr && reg_wr.idx == rcu_pkg::RCU_IDX_BASE
      |=> base_q == $past(reg_wr.data[6:0]);
  endproperty
  a_base_wr: assert property (p_base_wr) else $error("base not written");

endmodule // rcu_refresh
